// ===== design/atc_pkg.sv
// Constants, register map and helpers for analog torque command conditioning
`default_nettype none
package atc_pkg;
   // Datapath widths
   localparam int ATC_ADC_W = 12;
   localparam int ATC_MV_W = 18;
   localparam int ATC_NCH = 3;
   // Register byte addresses
   localparam logic [7:0] ATC_ADR_MODE = 8'h00;
   localparam logic [7:0] ATC_ADR_TSCALE = 8'h04;
   localparam logic [7:0] ATC_ADR_VSCALE = 8'h08;
   localparam logic [7:0] ATC_ADR_OFS [ATC_NCH] = '{8'h0C, 8'h10, 8'h14};
   localparam logic [7:0] ATC_ADR_DB [ATC_NCH] = '{8'h18, 8'h1C, 8'h20};
   localparam logic [7:0] ATC_ADR_LPF = 8'h24;
   localparam logic [7:0] ATC_ADR_TORQUE = 8'h28;
   localparam logic [7:0] ATC_ADR_VEL = 8'h2C;
   // Field positions in the mode register
   localparam int ATC_F_PRI = 0;
   localparam int ATC_F_SEC = 8;
   localparam int ATC_F_KIND = 16;
   localparam int ATC_F_FN1 = 20;
   localparam int ATC_F_FN2 = 24;
   // Values after reset
   localparam logic [4:0] ATC_RST_PRI = 5'h07;
   localparam logic [4:0] ATC_RST_SEC = 5'h15;
   localparam logic ATC_RST_KIND = 1'b0;
   localparam logic [1:0] ATC_RST_FN = 2'h3;
   localparam logic signed [15:0] ATC_RST_TSCALE = 16'sh0064;
   localparam logic signed [15:0] ATC_RST_VSCALE = 16'sh07D0;
   localparam logic [13:0] ATC_RST_LPF = 14'h01F4;
   // Limits, in panel units
   localparam logic signed [15:0] ATC_TSCALE_MAX = 16'sh07D0;
   localparam logic signed [15:0] ATC_VSCALE_MAX = 16'sh2710;
   localparam logic signed [15:0] ATC_OFS_MAX = 16'sh6AA4;
   localparam logic [15:0] ATC_LPF_MIN = 16'h0001;
   localparam logic [15:0] ATC_LPF_MAX = 16'h3E76;
   // Codes
   localparam logic [4:0] ATC_MODE_ANA_TORQUE = 5'h02;
   localparam logic [1:0] ATC_FN_VEL_LIMIT = 2'h1;
   localparam logic ATC_KIND_DIFF = 1'b1;
   // Scaling: mid code is 0 V, full code span is 2 x 10000 mV
   localparam logic [ATC_ADC_W-1:0] ATC_ADC_MID = 12'h800;
   localparam int ATC_FULL_MV = 10000;
   localparam int ATC_ADC_SHIFT = 11;
   localparam int ATC_OFS_PANEL = 2730;
   localparam int ATC_OFS_SHIFT = 16;
   localparam int ATC_OFS_RECIP = (1000 << ATC_OFS_SHIFT) / ATC_OFS_PANEL;
   localparam int ATC_GAIN_SHIFT = 26;
   localparam int ATC_GAIN_RECIP = (1 << ATC_GAIN_SHIFT) / ATC_FULL_MV;
   localparam int ATC_LPF_SHIFT = 14;

   // Legal operating mode codes
   function automatic logic atc_mode_ok(input logic [4:0] c);
      return (c >= 5'h01 && c <= 5'h08) || (c >= 5'h0A && c <= 5'h12) || c == 5'h15 || c == 5'h16;
   endfunction : atc_mode_ok

   // Legal input function codes
   function automatic logic atc_fn_ok(input logic [1:0] c);
      return c != 2'h0;
   endfunction : atc_fn_ok

   // Symmetric span check
   function automatic logic atc_in_span(input logic signed [15:0] v, input logic signed [15:0] lim);
      return (v >= -lim) && (v <= lim);
   endfunction : atc_in_span
endpackage : atc_pkg
`default_nettype wire

// ===== design/atc_lpf.sv
// First-order digital low-pass filter for one millivolt channel
`default_nettype none
module atc_lpf
   import atc_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Sample in
   input wire logic i_en,
   input wire logic signed [ATC_MV_W-1:0] i_x,
   input wire logic [13:0] i_k,
   // Filtered out
   output logic signed [ATC_MV_W-1:0] o_y
);
   localparam int PW = ATC_MV_W + 16;

   logic signed [ATC_MV_W-1:0] y_q; // Filter state
   logic signed [ATC_MV_W-1:0] y_d;
   logic signed [PW-1:0] step; // Error times coefficient

   // Move a fraction k/16384 of the error per sample
   always_comb
   begin
      step = PW'(i_x - y_q) * PW'($signed({1'b0, i_k}));
      y_d = y_q;
      if (i_en)
      begin
         y_d = y_q + ATC_MV_W'(step >>> ATC_LPF_SHIFT);
      end
   end

   // State register
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         y_q <= '0;
      end
      else
      begin
         y_q <= y_d;
      end
   end

   assign o_y = y_q;
endmodule : atc_lpf
`default_nettype wire

// ===== design/atc_cond.sv
// Offset removal and deadband for one filtered channel
`default_nettype none
module atc_cond
   import atc_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Filtered sample and settings
   input wire logic i_en,
   input wire logic signed [ATC_MV_W-1:0] i_x,
   input wire logic signed [15:0] i_ofs,
   input wire logic [7:0] i_db,
   // Conditioned out
   output logic signed [ATC_MV_W-1:0] o_y
);
   logic signed [31:0] ofs_p; // Panel units times reciprocal
   logic signed [ATC_MV_W-1:0] ofs_mv; // Offset in mV
   logic signed [ATC_MV_W-1:0] v; // Bias removed
   logic signed [ATC_MV_W-1:0] mag; // Magnitude of v
   logic signed [ATC_MV_W-1:0] db_mv; // Deadband in mV
   logic signed [ATC_MV_W-1:0] y_q;
   logic signed [ATC_MV_W-1:0] y_d;

   // Offset first, then deadband on what is left
   always_comb
   begin
      ofs_p = 32'(i_ofs) * 32'(ATC_OFS_RECIP);
      ofs_mv = ATC_MV_W'(ofs_p >>> ATC_OFS_SHIFT);
      v = i_x - ofs_mv;
      mag = (v < 0) ? -v : v;
      db_mv = $signed({{(ATC_MV_W-8){1'b0}}, i_db});
      y_d = y_q;
      if (i_en)
      begin
         y_d = (mag <= db_mv) ? '0 : v;
      end
   end

   // Result register
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         y_q <= '0;
      end
      else
      begin
         y_q <= y_d;
      end
   end

   assign o_y = y_q;

   dead_zero_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
      i_en && (mag <= db_mv) |=> o_y == '0)
      else $error("deadband did not force zero");
endmodule : atc_cond
`default_nettype wire

// ===== design/atc_top.sv
// Analog torque command conditioning: APB registers, sampling and scaling
// Operation
// - Two converters, twelve-bit samples each
// - Single-ended: in1 velocity, in2 torque
// - Differential in1 minus in2 drives torque
// - Input kind zero single, one differential
// - Primary mode legal set, reset seven
// - Secondary mode same set, reset 21
// - Mode two is plain analog torque
// - Inputs span minus to plus ten volts
// - Ten volts gives torque scale amps
// - Ten volts gives velocity scale, default 20
// - Three offsets remove bias, default zero
// - Three deadbands, 0 to 255 mV
// - Low-pass filter setting 1 to 15990
// - Input function codes 1..3, default 3
// - In1 code 1 limit, 3 unused
// - Torque scale held as amps times 100
// - Offsets held as volts times 2730
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`default_nettype none
module atc_top
   import atc_pkg::*;
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Converter samples
   input wire logic i_adc_valid,
   input wire logic [ATC_ADC_W-1:0] i_adc1_data,
   input wire logic [ATC_ADC_W-1:0] i_adc2_data,
   // Command outputs
   output logic o_cmd_valid,
   output logic signed [15:0] o_torque_cmd,
   output logic signed [15:0] o_velocity_cmd,
   output logic o_torque_mode
);
   // Bus decode
   logic acc; // Access phase
   logic wr_en; // Write access
   logic mapped; // Address hits a register
   logic wr_ok; // Write value acceptable
   logic [31:0] rd_data; // Read mux
   logic signed [15:0] pw16; // Low half of write data
   logic [4:0] pw_pri;
   logic [4:0] pw_sec;
   logic [1:0] pw_fn1;
   logic [1:0] pw_fn2;
   logic mode_wr_ok;

   // Settings
   logic [4:0] pri_q, pri_d; // primary_mode_sel
   logic [4:0] sec_q, sec_d; // secondary_mode_sel
   logic kind_q, kind_d; // input_kind
   logic [1:0] fn1_q, fn1_d; // in1_function
   logic [1:0] fn2_q, fn2_d; // in2_function
   logic signed [15:0] tscale_q, tscale_d; // torque_scale, 0.01 A
   logic signed [15:0] vscale_q, vscale_d; // velocity_scale, 0.01 rps
   logic signed [15:0] ofs_q [ATC_NCH]; // offset_in1/in2/diff
   logic signed [15:0] ofs_d [ATC_NCH];
   logic [7:0] db_q [ATC_NCH]; // deadzone_in1/in2/diff
   logic [7:0] db_d [ATC_NCH];
   logic [13:0] lpf_q, lpf_d; // input_lowpass
   logic [31:0] prdata_q, prdata_d;
   logic tmode_q, tmode_d;

   // Datapath
   logic signed [ATC_ADC_W:0] s1, s2; // Centred codes
   logic signed [26:0] p1, p2; // Codes times full scale
   logic signed [ATC_MV_W-1:0] raw [ATC_NCH]; // Unfiltered mV
   logic signed [ATC_MV_W-1:0] flt [ATC_NCH]; // Filtered mV
   logic signed [ATC_MV_W-1:0] cnd [ATC_NCH]; // Conditioned mV
   logic signed [ATC_MV_W-1:0] t_mv; // Torque source
   logic signed [ATC_MV_W-1:0] v_mv; // Velocity source
   logic signed [47:0] tq_p, vl_p; // Gain products
   logic vld1_q, vld2_q, vld3_q; // Pipeline valid
   logic signed [15:0] tq_q, tq_d;
   logic signed [15:0] vl_q, vl_d;

   // Bus phases and write fields
   always_comb
   begin
      acc = i_psel & i_penable;
      wr_en = acc & i_pwrite;
      pw16 = $signed(i_pwdata[15:0]);
      pw_pri = i_pwdata[ATC_F_PRI +: 5];
      pw_sec = i_pwdata[ATC_F_SEC +: 5];
      pw_fn1 = i_pwdata[ATC_F_FN1 +: 2];
      pw_fn2 = i_pwdata[ATC_F_FN2 +: 2];
      // Whole word refused if any field is illegal
      mode_wr_ok = atc_mode_ok(pw_pri) && atc_mode_ok(pw_sec)
         && atc_fn_ok(pw_fn1) && atc_fn_ok(pw_fn2);
   end

   // Address decode, write check and read mux
   always_comb
   begin
      mapped = 1'b1;
      wr_ok = 1'b0;
      rd_data = 32'h0000_0000;
      case (i_paddr)
         ATC_ADR_MODE:
         begin
            wr_ok = mode_wr_ok;
            rd_data[ATC_F_PRI +: 5] = pri_q;
            rd_data[ATC_F_SEC +: 5] = sec_q;
            rd_data[ATC_F_KIND] = kind_q;
            rd_data[ATC_F_FN1 +: 2] = fn1_q;
            rd_data[ATC_F_FN2 +: 2] = fn2_q;
         end
         ATC_ADR_TSCALE:
         begin
            wr_ok = atc_in_span(pw16, ATC_TSCALE_MAX);
            rd_data = 32'(tscale_q);
         end
         ATC_ADR_VSCALE:
         begin
            wr_ok = atc_in_span(pw16, ATC_VSCALE_MAX);
            rd_data = 32'(vscale_q);
         end
         ATC_ADR_LPF:
         begin
            wr_ok = (i_pwdata[15:0] >= ATC_LPF_MIN) && (i_pwdata[15:0] <= ATC_LPF_MAX);
            rd_data = {18'h00000, lpf_q};
         end
         // Live commands are read only
         ATC_ADR_TORQUE:
         begin
            rd_data = 32'(tq_q);
         end
         ATC_ADR_VEL:
         begin
            rd_data = 32'(vl_q);
         end
         default:
         begin
            mapped = 1'b0;
         end
      endcase
      // Per-channel offset and deadband words
      for (int c = 0; c < ATC_NCH; c++)
      begin
         if (i_paddr == ATC_ADR_OFS[c])
         begin
            mapped = 1'b1;
            wr_ok = atc_in_span(pw16, ATC_OFS_MAX);
            rd_data = 32'(ofs_q[c]);
         end
         if (i_paddr == ATC_ADR_DB[c])
         begin
            mapped = 1'b1;
            wr_ok = (i_pwdata[31:8] == 24'h000000);
            rd_data = {24'h000000, db_q[c]};
         end
      end
   end

   // Zero wait states; error on unmapped or refused writes
   assign o_pready = 1'b1;
   assign o_pslverr = acc & (~mapped | (i_pwrite & ~wr_ok));
   assign o_prdata = prdata_q;

   // Next settings
   always_comb
   begin
      pri_d = pri_q;
      sec_d = sec_q;
      kind_d = kind_q;
      fn1_d = fn1_q;
      fn2_d = fn2_q;
      tscale_d = tscale_q;
      vscale_d = vscale_q;
      lpf_d = lpf_q;
      ofs_d = ofs_q;
      db_d = db_q;
      // Read data captured in the setup phase
      prdata_d = (i_psel & ~i_penable) ? rd_data : prdata_q;
      if (wr_en && wr_ok)
      begin
         case (i_paddr)
            ATC_ADR_MODE:
            begin
               pri_d = pw_pri;
               sec_d = pw_sec;
               kind_d = i_pwdata[ATC_F_KIND];
               fn1_d = pw_fn1;
               fn2_d = pw_fn2;
            end
            ATC_ADR_TSCALE: tscale_d = pw16;
            ATC_ADR_VSCALE: vscale_d = pw16;
            ATC_ADR_LPF: lpf_d = i_pwdata[13:0];
            default: ;
         endcase
         for (int c = 0; c < ATC_NCH; c++)
         begin
            if (i_paddr == ATC_ADR_OFS[c])
            begin
               ofs_d[c] = pw16;
            end
            if (i_paddr == ATC_ADR_DB[c])
            begin
               db_d[c] = i_pwdata[7:0];
            end
         end
      end
      tmode_d = (pri_d == ATC_MODE_ANA_TORQUE);
   end

   // Settings registers
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         pri_q <= ATC_RST_PRI;
         sec_q <= ATC_RST_SEC;
         kind_q <= ATC_RST_KIND;
         fn1_q <= ATC_RST_FN;
         fn2_q <= ATC_RST_FN;
         tscale_q <= ATC_RST_TSCALE;
         vscale_q <= ATC_RST_VSCALE;
         lpf_q <= ATC_RST_LPF;
         ofs_q <= '{default: '0};
         db_q <= '{default: '0};
         prdata_q <= 32'h0000_0000;
         tmode_q <= 1'b0;
      end
      else
      begin
         pri_q <= pri_d;
         sec_q <= sec_d;
         kind_q <= kind_d;
         fn1_q <= fn1_d;
         fn2_q <= fn2_d;
         tscale_q <= tscale_d;
         vscale_q <= vscale_d;
         lpf_q <= lpf_d;
         ofs_q <= ofs_d;
         db_q <= db_d;
         prdata_q <= prdata_d;
         tmode_q <= tmode_d;
      end
   end

   assign o_torque_mode = tmode_q;

   // Codes to millivolts: full code span covers -10 V to +10 V
   always_comb
   begin
      s1 = $signed({1'b0, i_adc1_data}) - $signed({1'b0, ATC_ADC_MID});
      s2 = $signed({1'b0, i_adc2_data}) - $signed({1'b0, ATC_ADC_MID});
      p1 = 27'(s1) * 27'(ATC_FULL_MV);
      p2 = 27'(s2) * 27'(ATC_FULL_MV);
      raw[0] = ATC_MV_W'(p1 >>> ATC_ADC_SHIFT);
      raw[1] = ATC_MV_W'(p2 >>> ATC_ADC_SHIFT);
      raw[2] = raw[0] - raw[1];
   end

   // One filter and one conditioner per channel, filter first
   for (genvar g = 0; g < ATC_NCH; g++)
   begin : g_ch
      atc_lpf u_lpf (
         .i_core_clk(i_core_clk),
         .i_rst_n(i_rst_n),
         .i_en(i_adc_valid),
         .i_x(raw[g]),
         .i_k(lpf_q),
         .o_y(flt[g])
      );
      atc_cond u_cond (
         .i_core_clk(i_core_clk),
         .i_rst_n(i_rst_n),
         .i_en(vld1_q),
         .i_x(flt[g]),
         .i_ofs(ofs_q[g]),
         .i_db(db_q[g]),
         .o_y(cnd[g])
      );
   end

   // Source select and gain; in2 function only names the torque input
   always_comb
   begin
      t_mv = (kind_q == ATC_KIND_DIFF) ? cnd[2] : cnd[1];
      v_mv = (kind_q != ATC_KIND_DIFF && fn1_q == ATC_FN_VEL_LIMIT) ? cnd[0] : '0;
      // Signed products keep the scale's sign on the result
      tq_p = 48'(t_mv) * 48'(tscale_q) * 48'(ATC_GAIN_RECIP);
      vl_p = 48'(v_mv) * 48'(vscale_q) * 48'(ATC_GAIN_RECIP);
      tq_d = vld2_q ? 16'(tq_p >>> ATC_GAIN_SHIFT) : tq_q;
      vl_d = vld2_q ? 16'(vl_p >>> ATC_GAIN_SHIFT) : vl_q;
   end

   // Pipeline and command registers
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         vld1_q <= 1'b0;
         vld2_q <= 1'b0;
         vld3_q <= 1'b0;
         tq_q <= '0;
         vl_q <= '0;
      end
      else
      begin
         vld1_q <= i_adc_valid;
         vld2_q <= vld1_q;
         vld3_q <= vld2_q;
         tq_q <= tq_d;
         vl_q <= vl_d;
      end
   end

   assign o_cmd_valid = vld3_q;
   assign o_torque_cmd = tq_q;
   assign o_velocity_cmd = vl_q;

   // Checks
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_sample_in;
      i_adc_valid;
   endsequence
   sequence s_cmd_out;
      ##3 o_cmd_valid;
   endsequence

   pipe_latency_a: assert property (s_sample_in |-> s_cmd_out)
      else $error("command not valid three cycles after sample");
   mode_reset_a: assert property ($rose(i_rst_n) |-> pri_q == ATC_RST_PRI && sec_q == ATC_RST_SEC)
      else $error("mode reset values wrong");
   mode_legal_a: assert property (atc_mode_ok(pri_q) && atc_mode_ok(sec_q))
      else $error("illegal mode code held");
   mode_refuse_a: assert property (wr_en && i_paddr == ATC_ADR_MODE && !mode_wr_ok
      |-> o_pslverr ##1 $stable(pri_q) && $stable(sec_q))
      else $error("illegal mode write not refused");
   torque_mode_a: assert property (o_torque_mode == (pri_q == ATC_MODE_ANA_TORQUE))
      else $error("torque mode flag wrong");
   single_src_a: assert property (vld2_q && !kind_q && cnd[1] == '0 |=> o_torque_cmd == '0)
      else $error("single-ended torque not from input two");
   diff_src_a: assert property (vld2_q && kind_q && cnd[2] == '0 |=> o_torque_cmd == '0)
      else $error("differential torque not from difference");
   sign_inv_a: assert property (vld2_q && t_mv > 0 && tscale_q < 0 |=> o_torque_cmd <= 0)
      else $error("negative scale did not invert");
   vel_unused_a: assert property (vld2_q && fn1_q != ATC_FN_VEL_LIMIT |=> o_velocity_cmd == '0)
      else $error("unused input one gave velocity");
   lpf_range_a: assert property (16'(lpf_q) >= ATC_LPF_MIN && 16'(lpf_q) <= ATC_LPF_MAX)
      else $error("filter setting out of range");
endmodule : atc_top
`default_nettype wire

// ===== testbench/atc_host_model.sv
// Host controller model: converter samples of the two command voltages
`default_nettype none
module atc_host_model
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // Stimulus from the bench
   input wire logic i_run,
   input wire logic [1:0] i_gap,
   input wire logic [11:0] i_code1,
   input wire logic [11:0] i_code2,
   // Converter side
   output logic o_valid,
   output logic [11:0] o_data1,
   output logic [11:0] o_data2
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_q; // Idle cycles left before the next sample

   // Both codes leave together; between samples the lines churn
   always @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         o_valid <= 1'b0;
         o_data1 <= 12'h5A5;
         o_data2 <= 12'hA5A;
         wait_q <= 2'h0;
      end
      else if (i_run && wait_q == 2'h0)
      begin
         o_valid <= 1'b1;
         o_data1 <= i_code1; // Full span, 0x000 is -10 V
         o_data2 <= i_code2;
         wait_q <= i_gap;
      end
      else
      begin
         // Stale codes must never pass for a fresh sample
         o_valid <= 1'b0;
         o_data1 <= ~o_data1;
         o_data2 <= ~o_data2;
         if (wait_q != 2'h0)
            wait_q <= wait_q - 2'h1;
      end
   end
endmodule : atc_host_model
`default_nettype wire

// ===== testbench/atc_top_tb.sv
// Self-checking bench for analog torque command conditioning
`default_nettype none
module atc_top_tb
   import atc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_n, psel, penable, pwrite, pready, pslverr; // Bus
   logic run, corner, adc_valid, cmd_valid, torque_mode; // Stream
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [31:0] rnd = 32'h812FE423; // LFSR state, fixed seed so runs repeat
   logic [1:0] gap;
   logic [ATC_ADC_W-1:0] c1, c2, d1, d2;
   logic signed [15:0] torque, vel;
   logic [31:0] sh[12]; // Shadow of what the registers should hold
   logic [2:0] vp; // Expected strobe pipeline
   logic signed [15:0] qt[$], qv[$]; // Expected commands
   int err_total, compares, y[3], x[3];
   // Boundary writes: address, data, refusal expected
   logic [7:0] ra[14] = '{8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h0C, 8'h10, 8'h18, 8'h1C, 8'h24, 8'h24,
      8'h24, 8'h28, 8'h30};
   logic [31:0] rv[14] = '{32'h7D0, 32'h7D1, 32'hFFFFF82F, 32'h2710, 32'hFFFFD8EF, 32'h6AA4, 32'hFFFF955B,
      32'hFF, 32'h100, 32'h0, 32'h3E77, 32'h3E76, 32'h0, 32'h0};
   logic re[14] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

   atc_top uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
      .i_adc_valid(adc_valid), .i_adc1_data(d1), .i_adc2_data(d2), .o_cmd_valid(cmd_valid),
      .o_torque_cmd(torque), .o_velocity_cmd(vel), .o_torque_mode(torque_mode));
   atc_host_model host (.i_core_clk(clk), .i_rst_n(rst_n), .i_run(run), .i_gap(gap), .i_code1(c1),
      .i_code2(c2), .o_valid(adc_valid), .o_data1(d1), .o_data2(d2));

   // Clock, 25 ns period
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Verdict and end of run
   task automatic end_of_test;
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   // Legal operating mode codes
   function automatic logic ok(input int c);
      return (c >= 1 && c <= 8) || (c >= 10 && c <= 18) || c == 21 || c == 22;
   endfunction : ok

   // Mode word from its fields
   function automatic logic [31:0] mw(input logic [4:0] p, s, input logic k, input logic [1:0] f1, f2);
      return {6'h0, f2, 2'h0, f1, 3'h0, k, 3'h0, s, 3'h0, p};
   endfunction : mw

   // Code to millivolts, mid code is 0 V
   function automatic int mv(input logic [11:0] c);
      return ((int'(c) - 2048) * 10000) >>> 11;
   endfunction : mv

   // Offset then deadband; 24005 is 65536000 / 2730
   function automatic int cnd(input int yv, input int ch);
      int v;
      v = yv - ((int'(signed'(sh[3 + ch][15:0])) * 24005) >>> 16);
      return (v <= int'(sh[6 + ch][7:0]) && v >= -int'(sh[6 + ch][7:0])) ? 0 : v;
   endfunction : cnd

   // Gain: 10 V maps to the scale; 6710 is 2^26 / 10000
   function automatic logic signed [15:0] scl(input int v, input logic [31:0] s);
      longint p;
      p = (longint'(v) * longint'(signed'(s[15:0])) * 64'sd6710) >>> 26;
      return p[15:0];
   endfunction : scl

   // One APB transfer; reads are compared with the shadow
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic eerr);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // No cycle count assumed; a hang is left to the watchdog
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(32'(pslverr), 32'(eerr));
      if (wr && !eerr)
         sh[a[5:2]] = d;
      if (!wr)
         chk(rd, eerr ? 32'h0 : sh[a[5:2]]);
   endtask : apb

   // Program all settings, then stream samples and drain
   task automatic setup(input logic [31:0] m, ts, vs, o0, o1, o2, b0, b1, b2, lp, input logic cr);
      logic [31:0] v[10];
      v = '{m, ts, vs, o0, o1, o2, b0, b1, b2, lp};
      for (int i = 0; i < 10; i++)
         apb(1'b1, 8'(i * 4), v[i], 1'b0);
      repeat (2) @(posedge clk);
      chk(32'(torque_mode), 32'(m[4:0] == 5'h02));
      corner <= cr;
      run <= 1'b1;
      repeat (200) @(posedge clk);
      run <= 1'b0;
      repeat (8) @(posedge clk);
      chk(qt.size(), 32'h0);
   endtask : setup

   // Random codes, rails only in corner runs
   always @(posedge clk)
   begin
      c1 <= corner ? {12{rnd[3]}} : rnd[11:0];
      c2 <= corner ? {12{rnd[7]}} : rnd[23:12];
      gap <= rnd[29:28];
      rnd <= lfsr(rnd);
   end

   // Reference pipeline: filter, offset, deadband, gain
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         y = '{0, 0, 0};
         vp <= 3'h0;
      end
      else
      begin
         if (adc_valid)
         begin
            x[0] = mv(d1);
            x[1] = mv(d2);
            x[2] = x[0] - x[1];
            for (int i = 0; i < 3; i++)
               y[i] += ((x[i] - y[i]) * int'(sh[9][13:0])) >>> 14;
            qt.push_back(scl(sh[0][16] ? cnd(y[2], 2) : cnd(y[1], 1), sh[1]));
            qv.push_back((!sh[0][16] && sh[0][21:20] == 2'h1) ? scl(cnd(y[0], 0), sh[2]) : 16'sh0);
         end
         chk(32'(cmd_valid), 32'(vp[2]));
         if (cmd_valid && qt.size() > 0)
         begin
            chk(32'(torque), 32'(qt.pop_front()));
            chk(32'(vel), 32'(qv.pop_front()));
         end
         vp <= {vp[1:0], adc_valid};
      end
   end

   // Hang guard, well beyond the expected run length
   initial
   begin
      repeat (8000) @(posedge clk);
      err_total++;
      end_of_test;
   end

   // Main sequence
   initial
   begin
      {rst_n, psel, penable, pwrite, run, corner} = 6'h0;
      {paddr, pwdata} = '0;
      err_total = 0;
      compares = 0;
      sh = '{mw(5'h07, 5'h15, 1'b0, 2'h3, 2'h3), 32'h64, 32'h7D0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
         32'h1F4, 32'h0, 32'h0};
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 12; i++)
         apb(1'b0, 8'(i * 4), 32'h0, 1'b0);
      for (int c = 0; c < 32; c++)
      begin
         apb(1'b1, 8'h00, mw(5'(c), 5'h15, 1'b0, 2'h3, 2'h3), !ok(c));
         apb(1'b1, 8'h00, mw(5'h07, 5'(c), 1'b0, 2'h3, 2'h3), !ok(c));
      end
      apb(1'b1, 8'h00, mw(5'h07, 5'h15, 1'b0, 2'h0, 2'h3), 1'b1);
      apb(1'b1, 8'h00, mw(5'h07, 5'h15, 1'b0, 2'h3, 2'h0), 1'b1);
      for (int i = 0; i < 14; i++)
         apb(1'b1, ra[i], rv[i], re[i]);
      apb(1'b0, 8'h30, 32'h0, 1'b1);
      for (int i = 0; i < 10; i++)
         apb(1'b0, 8'(i * 4), 32'h0, 1'b0);
      // Wide input two deadband so single-ended torque hits zero now and then
      setup(mw(5'h02, 5'h15, 1'b0, 2'h1, 2'h3), 32'h96, 32'hFFFFF830, 32'h0, 32'h0, 32'h0, 32'h0, 32'hFF,
         32'h0, 32'h3E76, 1'b0);
      setup(mw(5'h07, 5'h15, 1'b1, 2'h3, 2'h3), 32'hFFFFF830, 32'h7D0, 32'h0, 32'h0, 32'hAAA, 32'h0, 32'h0,
         32'hFF, 32'h1F4, 1'b1);
      setup(mw(5'h02, 5'h16, 1'b0, 2'h1, 2'h2), 32'h7D0, 32'h2710, 32'hFFFF955C, 32'h1000, 32'h0, 32'h64,
         32'h0, 32'h0, 32'h1, 1'b0);
      end_of_test;
   end
endmodule : atc_top_tb
`default_nettype wire
